// ---- shared/ief_pkg.sv ----
// shared constants and carriers of the request-flag and error-flag block
// assumes one system clock, synchronous reset, word-indexed register bus
package ief_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] REQ_FLAGS_A_IDX = 8'h06;
    localparam logic [7:0] REQ_FLAGS_B_IDX = 8'h07;
    localparam logic [7:0] REQ_ENABLE_A_IDX = 8'h08;
    localparam logic [7:0] REQ_ENABLE_B_IDX = 8'h09;
    localparam logic [7:0] ERROR_FLAGS_IDX = 8'h0a;
    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    // field positions of flag and enable registers
    localparam int SET_BIT = 7;
    localparam int GLOBAL_BIT = 6;
    localparam int PIN_INVERT_BIT = 7;
    localparam int PIN_DRIVE_BIT = 7;
    localparam int PIN_GATE_BIT = 6;
    localparam int A_HIGH_ALERT = 6;
    localparam int A_LOW_ALERT = 5;
    localparam int A_IDLE = 4;
    localparam int A_TX_DONE = 3;
    localparam int A_RX_DONE = 2;
    localparam int A_ERROR = 1;
    localparam int A_FRAME_START = 0;
    localparam int B_CARD_DETECT = 5;
    localparam int B_TIMER_LSB = 0;
    // error register positions
    localparam int ERR_EEPROM = 7;
    localparam int ERR_WRITE = 6;
    localparam int ERR_OVERFLOW = 5;
    localparam int ERR_SHORT = 4;
    localparam int ERR_EMPTY = 3;
    localparam int ERR_COLLISION = 2;
    localparam int ERR_FRAMING = 1;
    localparam int ERR_INTEGRITY = 0;
    // transceiver state codes during which buffer writes are illegal
    localparam logic [2:0] COM_RX_WAIT = 3'h5;
    localparam logic [2:0] COM_WAIT_DATA = 3'h6;
    localparam logic [2:0] COM_RECEIVING = 3'h7;
    // shortest frames kept
    localparam logic [11:0] MIN_FRAME_BITS = 12'h004;
    localparam int EMD_MIN_BYTES = 3;
    localparam logic [11:0] EMD_MIN_BITS = 12'(EMD_MIN_BYTES * 8);

    typedef enum logic [1:0] {BUS_IDLE = 2'b00, BUS_ACK = 2'b01} ief_bus_state_e;

    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
    } ief_avs_req_s;

    typedef struct packed {
        logic out;
        logic oe;
    } ief_pin_s;

    typedef struct packed {
        logic highAlert;
        logic lowAlert;
        logic commandIdle;
        logic transmitDone;
        logic frameStart;
        logic cardDetected;
        logic [4:0] timerUnderflow;
        logic eepromCmdStart;
        logic eepromCmdFail;
        logic fifoWrite;
        logic fifoFull;
        logic crcTxActive;
        logic authActive;
        logic [2:0] comState;
        logic clCommandStart;
        logic multiFrameReceive;
        logic errorsInFifo;
        logic transmitRequest;
        logic fifoEmpty;
        logic frameEnd;
        logic [11:0] rxBitCount;
        logic emdSuppress;
        logic receiveStart;
        logic waitForDataEntry;
        logic collision;
        logic framingViolation;
        logic integrityMismatch;
    } ief_events_s;
endpackage

// ---- core/ief_bus_port.sv ----
// avalon-mm slave front end: one wait state, registered read data
// assumes the master holds its request until waitrequest is seen low
`timescale 1ns/1ps
module ief_bus_port
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire ief_pkg::ief_avs_req_s avs,
    output logic avsWaitrequest,
    output logic [31:0] avsReaddata,
    input wire logic [7:0] rdValue,
    output logic wrEn,
    output logic [7:0] wrData
);
    typedef struct packed {
        ief_pkg::ief_bus_state_e state;
        logic [31:0] readdata;
    } ief_bus_s;

    ief_bus_s bus_reg;
    ief_bus_s bus_next;

    // first cycle latches read data, second cycle completes
    always_comb
    begin
        bus_next = bus_reg;
        case (bus_reg.state)
            ief_pkg::BUS_IDLE:
            begin
                if (avs.read || avs.write)
                begin
                    bus_next.state = ief_pkg::BUS_ACK;
                    bus_next.readdata = {24'h000000, rdValue};
                end
            end
            default:
            begin
                bus_next.state = ief_pkg::BUS_IDLE;
            end
        endcase
    end

    // handshake outputs combinational so the master sees them at once
    assign avsWaitrequest = (avs.read || avs.write) && (bus_reg.state != ief_pkg::BUS_ACK);
    assign avsReaddata = bus_reg.readdata;
    assign wrEn = avs.write && (bus_reg.state == ief_pkg::BUS_ACK);
    assign wrData = avs.writedata[7:0];

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            bus_reg <= '{state: ief_pkg::BUS_IDLE, readdata: 32'h00000000};
        else
            bus_reg <= bus_next;
    end
endmodule

// ---- core/ief_pin_drive.sv ----
// interrupt pin stage: gating, polarity and drive type, registered
// assumes the board resolves the open-drain wire with a pull-up
`timescale 1ns/1ps
module ief_pin_drive
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic anyRequest,
    input wire logic pinGate,
    input wire logic pinInvert,
    input wire logic pushPull,
    output ief_pkg::ief_pin_s irqPin
);
    ief_pkg::ief_pin_s pin_reg;
    ief_pkg::ief_pin_s pin_next;
    logic level;

    // open drain can only pull low, so a high level means released
    always_comb
    begin
        level = (anyRequest && pinGate) ^ pinInvert;
        if (pushPull)
            pin_next = '{out: level, oe: 1'b1};
        else
            pin_next = '{out: 1'b0, oe: !level};
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            pin_reg <= '{out: 1'b0, oe: 1'b0};
        else
            pin_reg <= pin_next;
    end

    assign irqPin = pin_reg;
endmodule

// ---- core/ief_irq_core.sv ----
// request flags, request enables and contactless error flags
// assumes events from the transceiver, timers and buffer are one-cycle
// pulses or levels synchronous to clk_sys
// Functional notes
// - flags b write: bit 7 high sets, low clears each 1 in bits 5..0
// - global request raised whenever an enabled flag is active
// - card detect sets the card-detect flag
// - each timer underflow sets that timer's flag
// - polarity bit inverts the interrupt pin level
// - enable a bits 6..0 gate matching flags into global request
// - enable b bits 5..0 gate card-detect and timer flags into global
// - drive-type 1 means push-pull, 0 means open-drain pin
// - global request reaches pin only while pin gate bit is 1
// - eeprom error set when last eeprom command failed
// - buffer write during crc, receive phases or authentication flags error
// - write error cleared at command start without multi-frame, or after errors stored with multi-frame
// - write to full buffer sets overflow, stored data untouched
// - while overflow is set every further buffer write is dropped
// - fewer than 4 bits after valid start sets short-frame error
// - short frames discarded silently, decoder kept, no receive-done
// - short-frame error cleared at receive start or wait-for-data entry
// - transmit request with empty buffer sets empty-transmit error
// - error request flag set on write, overflow, framing, empty or integrity error
// - collision during reception sets collision flag
// - framing violation sets framing error and stops reception
// - parity or crc mismatch sets integrity error, reception goes on
`timescale 1ns/1ps
module ief_irq_core
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire ief_pkg::ief_avs_req_s avs,
    output logic avsWaitrequest,
    output logic [31:0] avsReaddata,
    input wire ief_pkg::ief_events_s events,
    output logic fifoWriteAccept,
    output logic frameDiscard,
    output logic receiveDone,
    output logic receiveStop,
    output logic anyEnabledRequest,
    output ief_pkg::ief_pin_s irqPin
);
    typedef struct packed {
        logic [6:0] flagsA;
        logic [5:0] flagsB;
        logic [7:0] enableA;
        logic [7:0] enableB;
        logic [7:0] errors;
        logic frameDiscard;
        logic receiveDone;
        logic receiveStop;
    } ief_core_s;

    ief_core_s core_reg;
    ief_core_s core_next;

    logic wrEn;
    logic [7:0] wrData;
    logic [7:0] rdValue;
    logic [7:0] selWord;
    logic selA;
    logic selB;
    logic selEnA;
    logic selEnB;
    logic wrIllegal;
    logic shortFrame;
    logic emdShort;
    logic [7:0] errSet;
    logic [7:0] errClr;
    logic [6:0] hwSetA;
    logic [5:0] hwSetB;
    logic rxPhaseClear;

    // register index of the current request
    function automatic logic [7:0] regIndex(input logic [7:0] addr);
        regIndex = addr;
    endfunction

    // set or clear every position written with a 1
    function automatic logic [6:0] setClear(
        input logic [6:0] cur,
        input logic [7:0] wd
    );
        if (wd[ief_pkg::SET_BIT])
            setClear = cur | wd[6:0];
        else
            setClear = cur & ~wd[6:0];
    endfunction

    // read mux; unmapped indices read as zero
    function automatic logic [7:0] readMux(
        input logic [7:0] idx,
        input ief_core_s s,
        input logic anyReq
    );
        if (idx == ief_pkg::REQ_FLAGS_A_IDX)
            readMux = {1'b0, s.flagsA};
        else if (idx == ief_pkg::REQ_FLAGS_B_IDX)
            readMux = {1'b0, anyReq, s.flagsB};
        else if (idx == ief_pkg::REQ_ENABLE_A_IDX)
            readMux = s.enableA;
        else if (idx == ief_pkg::REQ_ENABLE_B_IDX)
            readMux = s.enableB;
        else if (idx == ief_pkg::ERROR_FLAGS_IDX)
            readMux = s.errors;
        else
            readMux = 8'h00;
    endfunction

    ief_bus_port u_bus
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .avs(avs),
        .avsWaitrequest(avsWaitrequest),
        .avsReaddata(avsReaddata),
        .rdValue(rdValue),
        .wrEn(wrEn),
        .wrData(wrData)
    );

    // global request follows the flags without a register stage
    always_comb
    begin
        anyEnabledRequest = (|(core_reg.flagsA & core_reg.enableA[6:0]))
            || (|(core_reg.flagsB & core_reg.enableB[5:0]));
    end

    assign selWord = regIndex(avs.address);
    assign rdValue = readMux(selWord, core_reg, anyEnabledRequest);
    assign selA = wrEn && (selWord == ief_pkg::REQ_FLAGS_A_IDX);
    assign selB = wrEn && (selWord == ief_pkg::REQ_FLAGS_B_IDX);
    assign selEnA = wrEn && (selWord == ief_pkg::REQ_ENABLE_A_IDX);
    assign selEnB = wrEn && (selWord == ief_pkg::REQ_ENABLE_B_IDX);

    // buffer write checks; overflow stays sticky so later bytes drop too
    always_comb
    begin
        wrIllegal = events.crcTxActive || events.authActive
            || (events.comState == ief_pkg::COM_RX_WAIT)
            || (events.comState == ief_pkg::COM_WAIT_DATA)
            || (events.comState == ief_pkg::COM_RECEIVING);
        fifoWriteAccept = events.fifoWrite && !events.fifoFull
            && !core_reg.errors[ief_pkg::ERR_OVERFLOW];
    end

    // frame length checks at the end of each received frame
    always_comb
    begin
        shortFrame = events.frameEnd && (events.rxBitCount < ief_pkg::MIN_FRAME_BITS);
        emdShort = events.frameEnd && events.emdSuppress
            && (events.rxBitCount < ief_pkg::EMD_MIN_BITS);
        rxPhaseClear = events.receiveStart || events.waitForDataEntry;
    end

    // error register set terms from hardware events
    always_comb
    begin
        errSet = 8'h00;
        errSet[ief_pkg::ERR_EEPROM] = events.eepromCmdFail;
        errSet[ief_pkg::ERR_WRITE] = events.fifoWrite && wrIllegal;
        errSet[ief_pkg::ERR_OVERFLOW] = events.fifoWrite && events.fifoFull;
        errSet[ief_pkg::ERR_SHORT] = shortFrame;
        errSet[ief_pkg::ERR_EMPTY] = events.transmitRequest && events.fifoEmpty;
        errSet[ief_pkg::ERR_COLLISION] = events.collision;
        errSet[ief_pkg::ERR_FRAMING] = events.framingViolation;
        errSet[ief_pkg::ERR_INTEGRITY] = events.integrityMismatch;
    end

    // error register clear terms; the set terms win in the same cycle
    always_comb
    begin
        errClr = 8'h00;
        errClr[ief_pkg::ERR_EEPROM] = events.eepromCmdStart;
        if (events.multiFrameReceive)
            errClr[ief_pkg::ERR_WRITE] = events.errorsInFifo;
        else
            errClr[ief_pkg::ERR_WRITE] = events.clCommandStart;
        errClr[ief_pkg::ERR_OVERFLOW] = events.clCommandStart;
        errClr[ief_pkg::ERR_EMPTY] = events.clCommandStart;
        errClr[ief_pkg::ERR_SHORT] = rxPhaseClear;
        errClr[ief_pkg::ERR_COLLISION] = rxPhaseClear;
        errClr[ief_pkg::ERR_FRAMING] = rxPhaseClear;
        errClr[ief_pkg::ERR_INTEGRITY] = rxPhaseClear;
    end

    // hardware set terms of both request registers
    always_comb
    begin
        hwSetA = 7'h00;
        hwSetA[ief_pkg::A_HIGH_ALERT] = events.highAlert;
        hwSetA[ief_pkg::A_LOW_ALERT] = events.lowAlert;
        hwSetA[ief_pkg::A_IDLE] = events.commandIdle;
        hwSetA[ief_pkg::A_TX_DONE] = events.transmitDone;
        hwSetA[ief_pkg::A_RX_DONE] = events.frameEnd && !shortFrame && !emdShort;
        hwSetA[ief_pkg::A_ERROR] = errSet[ief_pkg::ERR_WRITE]
            || errSet[ief_pkg::ERR_OVERFLOW]
            || errSet[ief_pkg::ERR_FRAMING]
            || errSet[ief_pkg::ERR_EMPTY]
            || errSet[ief_pkg::ERR_INTEGRITY];
        hwSetA[ief_pkg::A_FRAME_START] = events.frameStart;
        hwSetB = 6'h00;
        hwSetB[ief_pkg::B_CARD_DETECT] = events.cardDetected;
        hwSetB[ief_pkg::B_TIMER_LSB +: 5] = events.timerUnderflow;
    end

    // next state: host writes first, hardware sets on top so none is lost
    always_comb
    begin
        logic [6:0] hostB;
        hostB = 7'h00;
        core_next = core_reg;
        if (selA)
            core_next.flagsA = setClear(core_reg.flagsA, wrData);
        if (selB)
        begin
            hostB = setClear({1'b0, core_reg.flagsB}, {wrData[7], 1'b0, wrData[5:0]});
            core_next.flagsB = hostB[5:0];
        end
        if (selEnA)
            core_next.enableA = wrData;
        if (selEnB)
            core_next.enableB = wrData;
        core_next.flagsA = core_next.flagsA | hwSetA;
        core_next.flagsB = core_next.flagsB | hwSetB;
        core_next.errors = (core_reg.errors & ~errClr) | errSet;
        // discard is a pulse; the decoder is never told to stop for it
        core_next.frameDiscard = shortFrame || emdShort;
        core_next.receiveDone = hwSetA[ief_pkg::A_RX_DONE];
        core_next.receiveStop = events.framingViolation;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            core_reg <= '{
                flagsA: 7'h00,
                flagsB: 6'h00,
                enableA: ief_pkg::REG_RESET,
                enableB: ief_pkg::REG_RESET,
                errors: ief_pkg::REG_RESET,
                frameDiscard: 1'b0,
                receiveDone: 1'b0,
                receiveStop: 1'b0
            };
        end
        else
        begin
            core_reg <= core_next;
        end
    end

    assign frameDiscard = core_reg.frameDiscard;
    assign receiveDone = core_reg.receiveDone;
    assign receiveStop = core_reg.receiveStop;

    // pin stage keeps gating, polarity and drive apart from the flags
    ief_pin_drive u_pin
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .anyRequest(anyEnabledRequest),
        .pinGate(core_reg.enableB[ief_pkg::PIN_GATE_BIT]),
        .pinInvert(core_reg.enableA[ief_pkg::PIN_INVERT_BIT]),
        .pushPull(core_reg.enableB[ief_pkg::PIN_DRIVE_BIT]),
        .irqPin(irqPin)
    );
endmodule

// ---- testbench/ief_irq_props.sv ----
// port checks of the request, error and pin logic
// assumes the bind below attaches it to every core instance
`timescale 1ns/1ps
module ief_irq_props
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire ief_pkg::ief_avs_req_s avs,
    input wire logic avsWaitrequest,
    input wire logic [31:0] avsReaddata,
    input wire ief_pkg::ief_events_s events,
    input wire logic fifoWriteAccept,
    input wire logic frameDiscard,
    input wire logic receiveDone,
    input wire logic receiveStop,
    input wire logic anyEnabledRequest,
    input wire ief_pkg::ief_pin_s irqPin
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // pending bus request and a frame too short to keep
    sequence s_pending;
        (avs.read || avs.write) && avsWaitrequest;
    endsequence
    sequence s_short_end;
        events.frameEnd && events.rxBitCount < ief_pkg::MIN_FRAME_BITS;
    endsequence

    // one wait state only, then the request completes
    chk_one_wait: assert property (s_pending |=> !avsWaitrequest)
        else $error("bus request kept waiting");
    chk_short_drop: assert property (s_short_end |=> frameDiscard && !receiveDone)
        else $error("short frame not discarded");
    chk_done_cause: assert property (receiveDone |-> $past(events.frameEnd)
        && $past(events.rxBitCount) >= ($past(events.emdSuppress)
        ? ief_pkg::EMD_MIN_BITS : ief_pkg::MIN_FRAME_BITS))
        else $error("receive done without a long enough frame");
    chk_discard_cause: assert property (frameDiscard |-> $past(events.frameEnd)
        && $past(events.rxBitCount) < ($past(events.emdSuppress)
        ? ief_pkg::EMD_MIN_BITS : ief_pkg::MIN_FRAME_BITS))
        else $error("frame discarded without cause");
    chk_stop_follow: assert property (events.framingViolation |=> receiveStop)
        else $error("reception not stopped");
    chk_stop_cause: assert property (receiveStop |-> $past(events.framingViolation))
        else $error("reception stopped without cause");
    chk_accept_gate: assert property (fifoWriteAccept |->
        events.fifoWrite && !events.fifoFull)
        else $error("write to full buffer accepted");
    chk_drain_low: assert property (!irqPin.oe |-> !irqPin.out)
        else $error("pin level without enable");
endmodule

bind ief_irq_core ief_irq_props u_props
(
    .clk_sys, .reset, .avs, .avsWaitrequest, .avsReaddata, .events, .fifoWriteAccept,
    .frameDiscard, .receiveDone, .receiveStop, .anyEnabledRequest, .irqPin
);

// ---- testbench/ief_host_model.sv ----
// host side of the interrupt wire with its board pull-up
// assumes the core drives the pin as a level plus output enable
`timescale 1ns/1ps
module ief_host_model
(
    input wire ief_pkg::ief_pin_s irqPin,
    output logic pinLevel
);
    // a released wire rises to the pull-up, never keeps its last value
    assign pinLevel = irqPin.oe ? irqPin.out : 1'b1;
endmodule

// ---- testbench/irq_enable_and_error_flags_tb.sv ----
// self-checking bench of the request flags, enables and error flags
// assumes the core, its bound checker and the host pin model
`timescale 1ns/1ps
module irq_enable_and_error_flags_tb;
    logic clk_sys, reset, avsWaitrequest, fifoWriteAccept, frameDiscard, receiveDone;
    logic receiveStop, anyEnabledRequest, pinLevel, accSeen;
    logic [2:0] outSeen;
    logic [7:0] rdv;
    logic [31:0] avsReaddata;
    ief_pkg::ief_avs_req_s avs;
    ief_pkg::ief_events_s events;
    ief_pkg::ief_pin_s irqPin;
    int err_count, check_count;

    ief_irq_core i_dut (.clk_sys, .reset, .avs, .avsWaitrequest, .avsReaddata, .events,
        .fifoWriteAccept, .frameDiscard, .receiveDone, .receiveStop, .anyEnabledRequest,
        .irqPin);
    ief_host_model i_host (.irqPin, .pinLevel);

    // 200 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // avalon master: request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk_sys);
        avs <= '{read: !wr, write: wr, address: idx, writedata: {24'h000000, wd}};
        @(posedge clk_sys);
        // no cycle count assumed; only the watchdog ends a hang
        while (avsWaitrequest !== 1'b0)
            @(posedge clk_sys);
        rdv = avsReaddata[7:0];
        avs <= '0;
    endtask

    task automatic expectReg(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(rdv, exp);
    endtask

    // one-cycle event; registered answers are caught a cycle later
    task automatic pulse(input ief_pkg::ief_events_s e);
        @(posedge clk_sys);
        events <= e;
        @(negedge clk_sys);
        accSeen = fifoWriteAccept;
        @(posedge clk_sys);
        events <= '0;
        @(negedge clk_sys);
        outSeen = {frameDiscard, receiveDone, receiveStop};
    endtask

    task automatic errCase(input ief_pkg::ief_events_s e, input logic [7:0] exp);
        pulse(e);
        expectReg(ief_pkg::ERROR_FLAGS_IDX, exp);
    endtask

    task automatic t_regs;
        for (int i = 6; i < 11; i++)
            expectReg(8'(i), ief_pkg::REG_RESET);
        bus(1'b1, ief_pkg::ERROR_FLAGS_IDX, 8'hff);
        expectReg(ief_pkg::ERROR_FLAGS_IDX, 8'h00);
        bus(1'b1, 8'h20, 8'hff);
        expectReg(8'h20, 8'h00);
        bus(1'b1, ief_pkg::REQ_FLAGS_B_IDX, 8'hbf);
        expectReg(ief_pkg::REQ_FLAGS_B_IDX, 8'h3f);
        bus(1'b1, ief_pkg::REQ_FLAGS_B_IDX, 8'h05);
        expectReg(ief_pkg::REQ_FLAGS_B_IDX, 8'h3a);
        bus(1'b1, ief_pkg::REQ_FLAGS_B_IDX, 8'h3a);
        $display("test registers done");
    endtask

    // events set flags; each enable gates only its own flag
    task automatic t_flags;
        bus(1'b1, ief_pkg::REQ_ENABLE_B_IDX, 8'h20);
        pulse('{default: 0, timerUnderflow: 5'h15, cardDetected: 1'b1});
        expectReg(ief_pkg::REQ_FLAGS_B_IDX, 8'h75);
        bus(1'b1, ief_pkg::REQ_FLAGS_B_IDX, 8'h3f);
        for (int j = 0; j < 13; j++)
        begin
            bus(1'b1, ief_pkg::REQ_FLAGS_A_IDX + 8'(j / 7), 8'h80 | 8'(1 << (j % 7)));
            bus(1'b1, ief_pkg::REQ_ENABLE_A_IDX + 8'(j / 7), 8'h7f ^ 8'(1 << (j % 7)));
            @(negedge clk_sys);
            check(8'(anyEnabledRequest), 8'h00);
            bus(1'b1, ief_pkg::REQ_ENABLE_A_IDX + 8'(j / 7), 8'(1 << (j % 7)));
            @(negedge clk_sys);
            check(8'(anyEnabledRequest), 8'h01);
            bus(1'b1, ief_pkg::REQ_FLAGS_A_IDX + 8'(j / 7), 8'h7f);
        end
        $display("test flags done");
    endtask

    // every mix of invert, gate and drive type; pin lags one cycle
    task automatic t_pin;
        logic lvl;
        bus(1'b1, ief_pkg::REQ_FLAGS_A_IDX, 8'h81);
        for (int m = 0; m < 8; m++)
        begin
            lvl = m[1] ^ m[0];
            bus(1'b1, ief_pkg::REQ_ENABLE_A_IDX, {m[0], 7'h01});
            bus(1'b1, ief_pkg::REQ_ENABLE_B_IDX, {m[2], m[1], 6'h00});
            repeat (2) @(negedge clk_sys);
            check(8'(pinLevel), 8'(lvl));
            check(8'(irqPin), {6'h00, m[2] & lvl, m[2] | !lvl});
        end
        bus(1'b1, ief_pkg::REQ_FLAGS_A_IDX, 8'h7f);
        $display("test pin done");
    endtask

    task automatic t_errors;
        errCase('{default: 0, eepromCmdFail: 1'b1}, 8'h80);
        errCase('{default: 0, eepromCmdStart: 1'b1}, 8'h00);
        errCase('{default: 0, collision: 1'b1}, 8'h04);
        errCase('{default: 0, framingViolation: 1'b1}, 8'h06);
        check(8'(outSeen), 8'h01);
        errCase('{default: 0, integrityMismatch: 1'b1}, 8'h07);
        expectReg(ief_pkg::REQ_FLAGS_A_IDX, 8'h02);
        errCase('{default: 0, receiveStart: 1'b1}, 8'h00);
        errCase('{default: 0, fifoWrite: 1'b1, fifoFull: 1'b1}, 8'h20);
        check(8'(accSeen), 8'h00);
        errCase('{default: 0, fifoWrite: 1'b1}, 8'h20);
        check(8'(accSeen), 8'h00);
        for (int k = 0; k < 5; k++)
        begin
            errCase('{default: 0, clCommandStart: 1'b1}, 8'h00);
            errCase('{default: 0, fifoWrite: 1'b1, crcTxActive: k == 3,
                authActive: k == 4, comState: (k < 3) ? 3'(k + 5) : 3'h0}, 8'h40);
            check(8'(accSeen), 8'h01);
        end
        errCase('{default: 0, fifoWrite: 1'b1, authActive: 1'b1}, 8'h40);
        errCase('{default: 0, clCommandStart: 1'b1, multiFrameReceive: 1'b1}, 8'h40);
        errCase('{default: 0, errorsInFifo: 1'b1, multiFrameReceive: 1'b1}, 8'h00);
        errCase('{default: 0, transmitRequest: 1'b1, fifoEmpty: 1'b1}, 8'h08);
        errCase('{default: 0, frameEnd: 1'b1, rxBitCount: 12'h003}, 8'h18);
        check(8'(outSeen), 8'h04);
        errCase('{default: 0, waitForDataEntry: 1'b1}, 8'h08);
        errCase('{default: 0, frameEnd: 1'b1, rxBitCount: 12'h004}, 8'h08);
        check(8'(outSeen), 8'h02);
        errCase('{default: 0, frameEnd: 1'b1, emdSuppress: 1'b1, rxBitCount: 12'h017},
            8'h08);
        check(8'(outSeen), 8'h04);
        $display("test errors done");
    endtask

    // run takes some 400 cycles; the limit leaves a wide margin
    initial
    begin
        #50us;
        err_count++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end

    // reset for ten cycles, then the scenarios in turn
    initial
    begin
        err_count = 0;
        check_count = 0;
        reset = 1'b1;
        avs = '0;
        events = '0;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        t_regs();
        t_flags();
        t_pin();
        t_errors();
        summarize();
    end
endmodule
